/* rtl/dclkg_pkg.sv */
// Package of constants for the clock generator indirect configuration block
// Contract
// (R1) Type 2 write loads eight-bit pre-scaler numerator
// (R2) Type 3 terminal count is data plus 257 (code sums in 9 bits, so data 255 wraps to 0)
// (R3) Reference divisor counts zero up to terminal count
// (R4) Type 4 stores group multiplier low byte
// (R5) Type 5 stores group multiplier bit zero
// (R6) Type 6 stores port synthesizer low byte
// (R7) Type 7 stores port synthesizer bit zero
// (R8) Select register type field picks element
// (R9) Direction bit and group number pick group
// (R10) Five-bit port number picks port synthesizer
// (R11) Pre-scaler denominator is terminal count plus one
// (R12) Low byte and high bit form nine-bit multiplier
package dclkg_pkg;
   localparam logic [11:0] DCLKG_SEL_OFS = 12'h000;
   localparam logic [11:0] DCLKG_DATA_OFS = 12'h004;
   localparam logic [11:0] DCLKG_SETUP_OFS = 12'h008;
   localparam logic [11:0] DCLKG_TC_OFS = 12'h00C;
   localparam logic [11:0] DCLKG_NUM_OFS = 12'h010;
   localparam logic [11:0] DCLKG_DIV_OFS = 12'h014;
   localparam logic [11:0] DCLKG_STAT_OFS = 12'h018;
   localparam int DCLKG_TYPE_LSB = 5;
   localparam int DCLKG_DIR_BIT = 4;
   localparam logic [7:0] DCLKG_RST8 = 8'h00;
   localparam logic [8:0] DCLKG_REF_BASE = 9'h101;
   localparam logic [1:0] DCLKG_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCLKG_RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      DCLKG_CT_SETUP = 3'h0,
      DCLKG_CT_PRETC = 3'h1,
      DCLKG_CT_NUM = 3'h2,
      DCLKG_CT_REFDIV = 3'h3,
      DCLKG_CT_GRP_LO = 3'h4,
      DCLKG_CT_GRP_HI = 3'h5,
      DCLKG_CT_SYN_LO = 3'h6,
      DCLKG_CT_SYN_HI = 3'h7
   } dclkg_ct_type;
endpackage

/* rtl/dclkg_top.sv */
// Clock generator indirect configuration registers with divider counters
module dclkg_top import dclkg_pkg::*; #(
   parameter int NGRP = 16,
   parameter int NPORT = 32
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Clock generator outputs
   output logic [7:0] setup_cfg,
   output logic [7:0] prescale_tc,
   output logic [8:0] prescale_den,
   output logic [7:0] prescale_num,
   output logic [8:0] ref_tc,
   output logic ref_tick,
   output logic prescale_tick,
   output logic [NGRP-1:0][8:0] rx_grp_mult,
   output logic [NGRP-1:0][8:0] tx_grp_mult,
   output logic [NPORT-1:0][8:0] syn_mult
);
   // Register state
   logic [7:0] sel_r, sel_nxt, setup_r, setup_nxt, tc_r, tc_nxt, num_r, num_nxt, div_r, div_nxt;
   logic [8:0] rxg_r [NGRP], rxg_nxt [NGRP], txg_r [NGRP], txg_nxt [NGRP];
   logic [8:0] syn_r [NPORT], syn_nxt [NPORT];
   logic [8:0] refcnt_r, refcnt_nxt, precnt_r, precnt_nxt;
   logic [8:0] acc_r, acc_nxt;
   logic reftick_r, reftick_nxt, pretick_r, pretick_nxt;
   // Bus state
   logic [11:0] awa_r, awa_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic haveaw_r, haveaw_nxt, havew_r, havew_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic wr_go;
   dclkg_ct_type ct;

   function automatic logic known_ofs(input logic [11:0] a);
      return a == DCLKG_SEL_OFS || a == DCLKG_DATA_OFS || a == DCLKG_SETUP_OFS || a == DCLKG_TC_OFS ||
             a == DCLKG_NUM_OFS || a == DCLKG_DIV_OFS || a == DCLKG_STAT_OFS;
   endfunction

   // Indirect read view of the selected element
   function automatic logic [7:0] ind_view(input logic [7:0] s);
      logic [3:0] g;
      logic [4:0] p;
      g = s[3:0];
      p = s[4:0];
      unique case (dclkg_ct_type'(s[7:DCLKG_TYPE_LSB])) // R8
         DCLKG_CT_SETUP: ind_view = setup_r;
         DCLKG_CT_PRETC: ind_view = tc_r;
         DCLKG_CT_NUM: ind_view = num_r;
         DCLKG_CT_REFDIV: ind_view = div_r;
         DCLKG_CT_GRP_LO: ind_view = s[DCLKG_DIR_BIT] ? txg_r[g][7:0] : rxg_r[g][7:0]; // R9
         DCLKG_CT_GRP_HI: ind_view = {7'h00, s[DCLKG_DIR_BIT] ? txg_r[g][8] : rxg_r[g][8]};
         DCLKG_CT_SYN_LO: ind_view = syn_r[p][7:0]; // R10
         DCLKG_CT_SYN_HI: ind_view = {7'h00, syn_r[p][8]};
      endcase
   endfunction

   assign s_axi_awready = !haveaw_r && !bv_r;
   assign s_axi_wready = !havew_r && !bv_r;
   assign s_axi_arready = !rv_r;
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = br_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rresp = rr_r;
   assign s_axi_rdata = rd_r;
   assign ct = dclkg_ct_type'(sel_r[7:DCLKG_TYPE_LSB]);

   always_comb begin
      haveaw_nxt = haveaw_r;
      havew_nxt = havew_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      bv_nxt = bv_r;
      br_nxt = br_r;
      rv_nxt = rv_r;
      rr_nxt = rr_r;
      rd_nxt = rd_r;
      sel_nxt = sel_r;
      setup_nxt = setup_r;
      tc_nxt = tc_r;
      num_nxt = num_r;
      div_nxt = div_r;
      rxg_nxt = rxg_r;
      txg_nxt = txg_r;
      syn_nxt = syn_r;
      if (s_axi_awvalid && s_axi_awready) begin
         haveaw_nxt = 1'b1;
         awa_nxt = {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         havew_nxt = 1'b1;
         wd_nxt = s_axi_wstrb[0] ? s_axi_wdata[7:0] : ind_view(sel_r);
      end
      // Both halves present, taken before the flags clear
      wr_go = haveaw_nxt && havew_nxt && !bv_r;
      if (bv_r && s_axi_bready) begin
         bv_nxt = 1'b0;
      end
      if (wr_go) begin
         haveaw_nxt = 1'b0;
         havew_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = known_ofs(awa_nxt) ? DCLKG_RESP_OKAY : DCLKG_RESP_SLVERR;
         if (awa_nxt == DCLKG_SEL_OFS) begin
            sel_nxt = wd_nxt;
         end else if (awa_nxt == DCLKG_DATA_OFS) begin
            unique case (ct) // R8
               DCLKG_CT_SETUP: setup_nxt = wd_nxt;
               DCLKG_CT_PRETC: tc_nxt = wd_nxt;
               DCLKG_CT_NUM: num_nxt = wd_nxt; // R1
               DCLKG_CT_REFDIV: div_nxt = wd_nxt;
               DCLKG_CT_GRP_LO: begin
                  if (sel_r[DCLKG_DIR_BIT]) txg_nxt[sel_r[3:0]][7:0] = wd_nxt; // R4 R9
                  else rxg_nxt[sel_r[3:0]][7:0] = wd_nxt; // R4 R9
               end
               DCLKG_CT_GRP_HI: begin
                  if (sel_r[DCLKG_DIR_BIT]) txg_nxt[sel_r[3:0]][8] = wd_nxt[0]; // R5 R9
                  else rxg_nxt[sel_r[3:0]][8] = wd_nxt[0]; // R5 R9
               end
               DCLKG_CT_SYN_LO: syn_nxt[sel_r[4:0]][7:0] = wd_nxt; // R6 R10
               DCLKG_CT_SYN_HI: syn_nxt[sel_r[4:0]][8] = wd_nxt[0]; // R7 R10
            endcase
         end
      end
      if (rv_r && s_axi_rready) begin
         rv_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_nxt = 1'b1;
         rr_nxt = known_ofs({s_axi_araddr[11:2], 2'h0}) ? DCLKG_RESP_OKAY : DCLKG_RESP_SLVERR;
         unique case ({s_axi_araddr[11:2], 2'h0})
            DCLKG_SEL_OFS: rd_nxt = {24'h000000, sel_r};
            DCLKG_DATA_OFS: rd_nxt = {24'h000000, ind_view(sel_r)};
            DCLKG_SETUP_OFS: rd_nxt = {24'h000000, setup_r};
            DCLKG_TC_OFS: rd_nxt = {24'h000000, tc_r};
            DCLKG_NUM_OFS: rd_nxt = {24'h000000, num_r};
            DCLKG_DIV_OFS: rd_nxt = {23'h000000, ref_tc};
            DCLKG_STAT_OFS: rd_nxt = {14'h0000, pretick_r, reftick_r, 7'h00, precnt_r};
            default: rd_nxt = 32'h00000000;
         endcase
      end
   end

   // Divider counters
   always_comb begin
      refcnt_nxt = (refcnt_r >= ref_tc) ? 9'h000 : refcnt_r + 9'h001; // R3
      reftick_nxt = (refcnt_r >= ref_tc); // R3
      acc_nxt = acc_r;
      precnt_nxt = precnt_r;
      pretick_nxt = 1'b0;
      if ({1'b0, precnt_r} + 10'h001 >= {1'b0, prescale_den}) begin // R11
         precnt_nxt = 9'h000;
         acc_nxt = acc_r + {1'b0, num_r};
         pretick_nxt = (acc_r + {1'b0, num_r} >= prescale_den); // R11
         if (pretick_nxt) acc_nxt = acc_r + {1'b0, num_r} - prescale_den;
      end else begin
         precnt_nxt = precnt_r + 9'h001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         haveaw_r <= 1'b0;
         havew_r <= 1'b0;
         awa_r <= 12'h000;
         wd_r <= DCLKG_RST8;
         bv_r <= 1'b0;
         br_r <= DCLKG_RESP_OKAY;
         rv_r <= 1'b0;
         rr_r <= DCLKG_RESP_OKAY;
         rd_r <= 32'h00000000;
         sel_r <= DCLKG_RST8;
         setup_r <= DCLKG_RST8;
         tc_r <= DCLKG_RST8;
         num_r <= DCLKG_RST8; // R1
         div_r <= DCLKG_RST8;
         for (int i = 0; i < NGRP; i++) begin
            rxg_r[i] <= 9'h000;
            txg_r[i] <= 9'h000;
         end
         for (int i = 0; i < NPORT; i++) begin
            syn_r[i] <= 9'h000;
         end
         refcnt_r <= 9'h000;
         precnt_r <= 9'h000;
         acc_r <= 9'h000;
         reftick_r <= 1'b0;
         pretick_r <= 1'b0;
      end else begin
         haveaw_r <= haveaw_nxt;
         havew_r <= havew_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rr_r <= rr_nxt;
         rd_r <= rd_nxt;
         sel_r <= sel_nxt;
         setup_r <= setup_nxt;
         tc_r <= tc_nxt;
         num_r <= num_nxt;
         div_r <= div_nxt;
         rxg_r <= rxg_nxt;
         txg_r <= txg_nxt;
         syn_r <= syn_nxt;
         refcnt_r <= refcnt_nxt;
         precnt_r <= precnt_nxt;
         acc_r <= acc_nxt;
         reftick_r <= reftick_nxt;
         pretick_r <= pretick_nxt;
      end
   end

   // Output mapping
   assign setup_cfg = setup_r;
   assign prescale_tc = tc_r;
   assign prescale_den = {1'b0, tc_r} + 9'h001; // R11
   assign prescale_num = num_r;
   assign ref_tc = {1'b0, div_r} + DCLKG_REF_BASE; // R2
   assign ref_tick = reftick_r;
   assign prescale_tick = pretick_r;
   generate
      for (genvar i = 0; i < NGRP; i++) begin : g_grp
         assign rx_grp_mult[i] = rxg_r[i]; // R12
         assign tx_grp_mult[i] = txg_r[i]; // R12
      end
      for (genvar i = 0; i < NPORT; i++) begin : g_syn
         assign syn_mult[i] = syn_r[i]; // R12
      end
   endgenerate
endmodule // dclkg_top

/* tb/dclkg_checker.sv */
// Bus and divider checks for the clock generator configuration block
module dclkg_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Divider settings
   input wire logic [7:0] prescale_tc,
   input wire logic [8:0] prescale_den,
   input wire logic [8:0] ref_tc,
   input wire logic ref_tick
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [8:0] gap_r;
   logic [8:0] tc_r;
   logic seen_r;
   // Cycles since the last reference tick
   always_ff @(posedge aclk) begin
      tc_r <= ref_tc;
      gap_r <= (!aresetn || ref_tick) ? 9'h000 : gap_r + 9'h001;
      seen_r <= (!aresetn || ref_tc != tc_r) ? 1'b0 : (seen_r || ref_tick);
   end
   a_den_plus_one: assert property (prescale_den == {1'b0, prescale_tc} + 9'h001)
      else $error("prescale denominator differs from count plus one");
   a_ref_floor: assert property (ref_tc >= 9'h101)
      else $error("reference count below base");
   a_ref_period: assert property (ref_tick && seen_r && ref_tc == tc_r |-> gap_r == ref_tc)
      else $error("reference tick spacing wrong");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response missing");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answer pending");
   c_ref_tick: cover property (ref_tick && seen_r);
   c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
   c_rd_wait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // dclkg_checker

/* tb/tb_top.sv */
// Self-checking bench for the clock generator configuration block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dclkg_pkg::*;
   typedef struct {logic [7:0] sel; logic [7:0] dat; logic [8:0] exp;} dclkg_row_type;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_tick, prescale_tick;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rdv;
   logic [7:0] setup_cfg, prescale_tc, prescale_num;
   logic [8:0] prescale_den, ref_tc;
   logic [15:0][8:0] rx_grp_mult, tx_grp_mult;
   logic [31:0][8:0] syn_mult;
   int n_errors = 0;
   int comparisons = 0;
   int t;
   dclkg_row_type rows [11] = '{'{8'h40, 8'hA5, 9'h0A5}, '{8'h60, 8'h3F, 9'h140}, '{8'h83, 8'h5A, 9'h05A},
      '{8'hA3, 8'h01, 9'h15A}, '{8'h93, 8'hC3, 9'h0C3}, '{8'hBF, 8'h01, 9'h100}, '{8'hC0, 8'h12, 9'h012},
      '{8'hDF, 8'h77, 9'h077}, '{8'hFF, 8'h01, 9'h177}, '{8'h20, 8'h09, 9'h00A}, '{8'h00, 8'h70, 9'h070}};
   dclkg_top #(.NGRP(16), .NPORT(32)) uut (.*);
   always #20 aclk = ~aclk;
   function automatic logic [8:0] probe(input logic [7:0] s);
      case (s[7:5])
         3'h0: probe = {1'b0, setup_cfg};
         3'h1: probe = prescale_den;
         3'h2: probe = {1'b0, prescale_num};
         3'h3: probe = ref_tc;
         3'h4, 3'h5: probe = s[4] ? tx_grp_mult[s[3:0]] : rx_grp_mult[s[3:0]];
         default: probe = syn_mult[s[4:0]];
      endcase
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input int lag);
      int n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!tb) begin
         if (n > lag) s_axi_bready <= 1'b1;
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         n++;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input int lag);
      int n;
      logic ta, tr;
      n = 0;
      tr = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!tr) begin
         if (n > lag) s_axi_rready <= 1'b1;
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         rdv = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         n++;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic close_out;
      $display("Mismatches %0d of %0d comparisons", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      close_out;
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         wr(DCLKG_SEL_OFS, rows[i].sel, 0);
         wr(DCLKG_DATA_OFS, rows[i].dat, 0);
         chk(resp, DCLKG_RESP_OKAY);
         chk(probe(rows[i].sel), rows[i].exp);
         rd(DCLKG_DATA_OFS, 0);
         chk(rdv[7:0], rows[i].dat);
         chk(resp, DCLKG_RESP_OKAY);
      end
      chk(probe(8'hA3), 9'h15A);
      chk(probe(8'hC0), 9'h012);
      wr(DCLKG_SEL_OFS, 8'h93, 3);
      rd(DCLKG_DATA_OFS, 3);
      chk(rdv[7:0], 8'hC3);
      wr(12'h0FC, 8'h11, 0);
      chk(resp, DCLKG_RESP_SLVERR);
      rd(12'h0FC, 0);
      chk(resp, DCLKG_RESP_SLVERR);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(prescale_num, 8'h00);
      chk(ref_tc, 9'h101);
      chk(rx_grp_mult[3], 9'h000);
      chk(syn_mult[31], 9'h000);
      chk(prescale_den, 9'h001);
      rd(DCLKG_DIV_OFS, 0);
      chk(rdv[8:0], 9'h101);
      t = 0;
      while (!ref_tick && t < 600) begin
         @(negedge aclk);
         t++;
      end
      t = 0;
      do begin
         @(negedge aclk);
         t++;
      end while (!ref_tick && t < 600);
      chk(t, 258);
      // Pre-scaler ratio: num 2 over den 4, one tick per 8 cycles
      wr(DCLKG_SEL_OFS, 8'h20, 0);
      wr(DCLKG_DATA_OFS, 8'h03, 0);
      wr(DCLKG_SEL_OFS, 8'h40, 0);
      wr(DCLKG_DATA_OFS, 8'h02, 0);
      chk(prescale_tc, 8'h03);
      chk(prescale_den, 9'h004);
      repeat (16) @(negedge aclk);
      t = 0;
      repeat (64) begin
         @(negedge aclk);
         if (prescale_tick === 1'b1) t++;
      end
      chk(t, 8);
      close_out;
   end
endmodule // tb_top
bind dclkg_top dclkg_checker chk_u (.*);
